// File: hdl/svcr_pkg.sv
// Constants and types for the supervisor channel configuration registers
package svcr_pkg;

  // Register offsets
  localparam logic [7:0] SVCR_OFS_TEST_IRQ = 8'h1c;
  localparam logic [7:0] SVCR_OFS_VENDOR_IRQ = 8'h1d;
  localparam logic [7:0] SVCR_OFS_CH_EN = 8'h1e;
  localparam logic [7:0] SVCR_OFS_RANGE = 8'h1f;
  localparam logic [7:0] SVCR_OFS_CH1_UV = 8'h20;
  localparam logic [7:0] SVCR_OFS_CH1_OV = 8'h21;
  localparam logic [7:0] SVCR_OFS_CH1_DEB = 8'h24;

  // Writable bit masks
  localparam logic [7:0] SVCR_TEST_IRQ_MASK = 8'h0b;
  localparam logic [7:0] SVCR_VENDOR_IRQ_MASK = 8'ha0;

  // Field positions
  localparam int SVCR_SEC_BIT = 3;
  localparam int SVCR_DONE_BIT = 1;
  localparam int SVCR_FAIL_BIT = 0;
  localparam int SVCR_CRC_BIT = 7;
  localparam int SVCR_DISAGREE_BIT = 5;
  localparam int SVCR_OVERVOLT_SETTLE_CODE_LSB = 4;
  localparam int SVCR_UNDERVOLT_SETTLE_CODE_LSB = 0;

  // Reset values (variant defaults are arbitrary plain values)
  localparam logic [7:0] SVCR_TEST_IRQ_RST = 8'h00;
  localparam logic [7:0] SVCR_VENDOR_IRQ_RST = 8'h00;
  localparam logic [3:0] SVCR_CH_EN_HI_RST = 4'h0;
  localparam logic [3:0] SVCR_CH_EN_LO_RST = 4'h0;
  localparam logic [3:0] SVCR_RANGE_HI_RST = 4'h0;
  localparam logic [3:0] SVCR_RANGE_LO_RST = 4'h0;
  localparam logic [7:0] SVCR_CH1_UV_RST = 8'h00;
  localparam logic [7:0] SVCR_CH1_OV_RST = 8'h00;
  localparam logic [3:0] SVCR_OVERVOLT_SETTLE_CODE_RST = 4'h0;
  localparam logic [3:0] SVCR_UNDERVOLT_SETTLE_CODE_RST = 4'h0;

  // Threshold scaling in millivolts
  localparam int SVCR_LOW_BASE_MV = 200;
  localparam int SVCR_LOW_STEP_MV = 5;
  localparam int SVCR_HIGH_BASE_MV = 800;
  localparam int SVCR_HIGH_STEP_MV = 20;

  // Debounce timing
  localparam int SVCR_CLK_PERIOD_NS = 100;
  localparam int SVCR_DEB_BASE_NS = 100;
  localparam int SVCR_DEB_BASE_CYC = (SVCR_DEB_BASE_NS + SVCR_CLK_PERIOD_NS - 1)
                                     / SVCR_CLK_PERIOD_NS;
  localparam logic [3:0] SVCR_DEB_MAX_CODE = 4'ha;

  typedef struct packed {
    logic sec;
    logic done;
    logic fail;
    logic crc;
    logic disagree;
  } svcr_irq_t;

  typedef struct packed {
    logic [7:0] test_irq;
    logic [7:0] vendor_irq;
    logic [7:0] ch_en;
    logic [7:0] range;
    logic [7:0] uv_code;
    logic [7:0] ov_code;
    logic [7:0] deb;
    logic [10:0] uv_cnt;
    logic [10:0] ov_cnt;
    logic uv_fault;
    logic ov_fault;
    logic [12:0] uv_mv;
    logic [12:0] ov_mv;
    svcr_irq_t irq;
    logic [7:0] rdata;
  } svcr_state_t;

endpackage

// File: hdl/svcr_channel_regs.sv
// Channel configuration register slice of a multichannel voltage supervisor
// How it works
// - Test bit 3 gates corrected-memory-error interrupt
// - Test bit 1 gates self-test done interrupt
// - Test bit 0 gates self-test fail interrupt
// - Vendor bit 7 maps startup CRC failure
// - Vendor bit 5 maps reset-output disagreement
// - Enable bit k monitors channel k+1
// - Upper enables reset zero, lower variant default
// - Range bit k: 0 gives 1x, 1 gives 4x
// - Channel 1 undervoltage 8-bit threshold code
// - Channel 1 overvoltage 8-bit threshold code
// - 1x maps 0.2 V upward, 5 mV steps
// - 4x maps 0.8 V upward, 20 mV steps
// - Overvoltage fault waits stable debounce time
// - Undervoltage fault waits stable debounce time
// - Code doubles from 0.1 us, caps 102.4 us
`timescale 1ns/1ps
`default_nettype none

module svcr_channel_regs
  import svcr_pkg::*;
#(
  parameter logic [7:0] TEST_IRQ_RST = SVCR_TEST_IRQ_RST,
  parameter logic [3:0] CH_EN_LO_RST = SVCR_CH_EN_LO_RST,
  parameter logic [3:0] RANGE_LO_RST = SVCR_RANGE_LO_RST,
  parameter logic [7:0] CH1_UV_RST = SVCR_CH1_UV_RST,
  parameter logic [7:0] CH1_OV_RST = SVCR_CH1_OV_RST,
  parameter logic [3:0] UNDERVOLT_SETTLE_CODE_RST = SVCR_UNDERVOLT_SETTLE_CODE_RST
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Internal fault events
  input wire logic sec_event,
  input wire logic selftest_done,
  input wire logic selftest_fail,
  input wire logic startup_crc_fail,
  input wire logic reset_output_disagree,
  output var svcr_irq_t irq_req,
  // Channel settings
  output logic [7:0] channel_monitor_enable,
  output logic [7:0] channel_range_scale,
  output logic [7:0] fast_undervolt_threshold,
  output logic [7:0] fast_overvolt_threshold,
  output logic [12:0] ch1_undervolt_mv,
  output logic [12:0] ch1_overvolt_mv,
  output logic [3:0] overvolt_settle_code,
  output logic [3:0] undervolt_settle_code,
  // Channel 1 comparators and faults
  input wire logic ch1_uv_cmp,
  input wire logic ch1_ov_cmp,
  output logic ch1_uv_fault,
  output logic ch1_ov_fault
);

  svcr_state_t s_q;
  svcr_state_t s_d;
  logic [10:0] uv_limit;
  logic [10:0] ov_limit;

  function automatic logic [12:0] thr_mv(input logic [7:0] code, input logic scale);
    int mv;
    mv = scale ? SVCR_HIGH_BASE_MV + int'(code) * SVCR_HIGH_STEP_MV
               : SVCR_LOW_BASE_MV + int'(code) * SVCR_LOW_STEP_MV;
    return mv[12:0];
  endfunction

  function automatic logic [10:0] deb_cycles(input logic [3:0] code);
    int cyc;
    cyc = (code >= SVCR_DEB_MAX_CODE) ? (SVCR_DEB_BASE_CYC << int'(SVCR_DEB_MAX_CODE))
                                      : (SVCR_DEB_BASE_CYC << int'(code));
    return cyc[10:0];
  endfunction

  assign uv_limit = deb_cycles(s_q.deb[SVCR_UNDERVOLT_SETTLE_CODE_LSB +: 4]);
  assign ov_limit = deb_cycles(s_q.deb[SVCR_OVERVOLT_SETTLE_CODE_LSB +: 4]);

  always_comb begin
    s_d = s_q;
    // Register writes, reserved bits masked
    if (reg_wr) begin
      case (reg_addr)
        SVCR_OFS_TEST_IRQ: s_d.test_irq = reg_wdata & SVCR_TEST_IRQ_MASK;
        SVCR_OFS_VENDOR_IRQ: s_d.vendor_irq = reg_wdata & SVCR_VENDOR_IRQ_MASK;
        SVCR_OFS_CH_EN: s_d.ch_en = reg_wdata;
        SVCR_OFS_RANGE: s_d.range = reg_wdata;
        SVCR_OFS_CH1_UV: s_d.uv_code = reg_wdata;
        SVCR_OFS_CH1_OV: s_d.ov_code = reg_wdata;
        SVCR_OFS_CH1_DEB: s_d.deb = reg_wdata;
        default: s_d.deb = s_q.deb;
      endcase
    end
    // Interrupt gating
    s_d.irq.sec = sec_event & s_q.test_irq[SVCR_SEC_BIT];
    s_d.irq.done = selftest_done & s_q.test_irq[SVCR_DONE_BIT];
    s_d.irq.fail = selftest_fail & s_q.test_irq[SVCR_FAIL_BIT];
    s_d.irq.crc = startup_crc_fail & s_q.vendor_irq[SVCR_CRC_BIT];
    s_d.irq.disagree = reset_output_disagree & s_q.vendor_irq[SVCR_DISAGREE_BIT];
    // Threshold voltages
    s_d.uv_mv = thr_mv(s_q.uv_code, s_q.range[0]);
    s_d.ov_mv = thr_mv(s_q.ov_code, s_q.range[0]);
    // Undervoltage debounce
    if (!s_q.ch_en[0] || !ch1_uv_cmp) begin
      s_d.uv_cnt = '0;
      s_d.uv_fault = 1'b0;
    end else begin
      if (s_q.uv_cnt < uv_limit) begin
        s_d.uv_cnt = s_q.uv_cnt + 11'h001;
      end
      s_d.uv_fault = (s_q.uv_cnt + 11'h001) >= uv_limit;
    end
    // Overvoltage debounce
    if (!s_q.ch_en[0] || !ch1_ov_cmp) begin
      s_d.ov_cnt = '0;
      s_d.ov_fault = 1'b0;
    end else begin
      if (s_q.ov_cnt < ov_limit) begin
        s_d.ov_cnt = s_q.ov_cnt + 11'h001;
      end
      s_d.ov_fault = (s_q.ov_cnt + 11'h001) >= ov_limit;
    end
    // Register reads
    if (reg_rd) begin
      case (reg_addr)
        SVCR_OFS_TEST_IRQ: s_d.rdata = s_q.test_irq;
        SVCR_OFS_VENDOR_IRQ: s_d.rdata = s_q.vendor_irq;
        SVCR_OFS_CH_EN: s_d.rdata = s_q.ch_en;
        SVCR_OFS_RANGE: s_d.rdata = s_q.range;
        SVCR_OFS_CH1_UV: s_d.rdata = s_q.uv_code;
        SVCR_OFS_CH1_OV: s_d.rdata = s_q.ov_code;
        SVCR_OFS_CH1_DEB: s_d.rdata = s_q.deb;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.test_irq <= TEST_IRQ_RST & SVCR_TEST_IRQ_MASK;
      s_q.vendor_irq <= SVCR_VENDOR_IRQ_RST;
      s_q.ch_en <= {SVCR_CH_EN_HI_RST, CH_EN_LO_RST};
      s_q.range <= {SVCR_RANGE_HI_RST, RANGE_LO_RST};
      s_q.uv_code <= CH1_UV_RST;
      s_q.ov_code <= CH1_OV_RST;
      s_q.deb <= {SVCR_OVERVOLT_SETTLE_CODE_RST, UNDERVOLT_SETTLE_CODE_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign irq_req = s_q.irq;
  assign channel_monitor_enable = s_q.ch_en;
  assign channel_range_scale = s_q.range;
  assign fast_undervolt_threshold = s_q.uv_code;
  assign fast_overvolt_threshold = s_q.ov_code;
  assign ch1_undervolt_mv = s_q.uv_mv;
  assign ch1_overvolt_mv = s_q.ov_mv;
  assign overvolt_settle_code = s_q.deb[SVCR_OVERVOLT_SETTLE_CODE_LSB +: 4];
  assign undervolt_settle_code = s_q.deb[SVCR_UNDERVOLT_SETTLE_CODE_LSB +: 4];
  assign ch1_uv_fault = s_q.uv_fault;
  assign ch1_ov_fault = s_q.ov_fault;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_sec_irq_gate: assert property (
    sec_event |=> (irq_req.sec == $past(s_q.test_irq[SVCR_SEC_BIT])))
    else $error("corrected error interrupt gating wrong");
  chk_sec_irq_quiet: assert property (
    !sec_event |=> !irq_req.sec)
    else $error("corrected error interrupt without event");

  chk_done_irq_gate: assert property (
    selftest_done |=> (irq_req.done == $past(s_q.test_irq[SVCR_DONE_BIT])))
    else $error("self-test done interrupt gating wrong");
  chk_done_irq_quiet: assert property (
    !selftest_done |=> !irq_req.done)
    else $error("self-test done interrupt without event");

  chk_fail_irq_gate: assert property (
    selftest_fail |=> (irq_req.fail == $past(s_q.test_irq[SVCR_FAIL_BIT])))
    else $error("self-test fail interrupt gating wrong");
  chk_fail_irq_quiet: assert property (
    !selftest_fail |=> !irq_req.fail)
    else $error("self-test fail interrupt without event");

  chk_crc_irq_gate: assert property (
    (startup_crc_fail && !s_q.vendor_irq[SVCR_CRC_BIT]) |=> !irq_req.crc)
    else $error("startup crc interrupt not masked");
  chk_crc_irq_pass: assert property (
    (startup_crc_fail && s_q.vendor_irq[SVCR_CRC_BIT]) |=> irq_req.crc)
    else $error("startup crc interrupt lost");

  chk_disagree_gate: assert property (
    (reset_output_disagree && s_q.vendor_irq[SVCR_DISAGREE_BIT]) |=> irq_req.disagree)
    else $error("reset disagreement interrupt lost");
  chk_disagree_masked: assert property (
    (reset_output_disagree && !s_q.vendor_irq[SVCR_DISAGREE_BIT]) |=> !irq_req.disagree)
    else $error("reset disagreement interrupt not masked");

  chk_reserved_bits_zero: assert property (
    ((s_q.test_irq & ~SVCR_TEST_IRQ_MASK) == 8'h00)
    && ((s_q.vendor_irq & ~SVCR_VENDOR_IRQ_MASK) == 8'h00))
    else $error("reserved bit set");

  chk_test_irq_write: assert property (
    (reg_wr && reg_addr == SVCR_OFS_TEST_IRQ)
    |=> s_q.test_irq == ($past(reg_wdata) & SVCR_TEST_IRQ_MASK))
    else $error("test interrupt enable write wrong");
  chk_read_test_irq: assert property (
    (reg_rd && reg_addr == SVCR_OFS_TEST_IRQ)
    |=> (reg_rdata & ~SVCR_TEST_IRQ_MASK) == 8'h00)
    else $error("test interrupt enable reserved bits read set");

  chk_vendor_irq_write: assert property (
    (reg_wr && reg_addr == SVCR_OFS_VENDOR_IRQ)
    |=> s_q.vendor_irq == ($past(reg_wdata) & SVCR_VENDOR_IRQ_MASK))
    else $error("vendor interrupt enable write wrong");
  chk_read_vendor_irq: assert property (
    (reg_rd && reg_addr == SVCR_OFS_VENDOR_IRQ)
    |=> (reg_rdata & ~SVCR_VENDOR_IRQ_MASK) == 8'h00)
    else $error("vendor interrupt enable reserved bits read set");

  chk_enable_write: assert property (
    (reg_wr && reg_addr == SVCR_OFS_CH_EN) |=> channel_monitor_enable == $past(reg_wdata))
    else $error("channel enable write not stored");
  chk_enable_hold: assert property (
    (!reg_wr || reg_addr != SVCR_OFS_CH_EN) |=> $stable(channel_monitor_enable))
    else $error("channel enable changed without write");
  chk_read_ch_en: assert property (
    (reg_rd && reg_addr == SVCR_OFS_CH_EN) |=> reg_rdata == $past(channel_monitor_enable))
    else $error("channel enable read back wrong");

  chk_range_write: assert property (
    (reg_wr && reg_addr == SVCR_OFS_RANGE) |=> channel_range_scale == $past(reg_wdata))
    else $error("range write not stored");
  chk_read_range: assert property (
    (reg_rd && reg_addr == SVCR_OFS_RANGE) |=> reg_rdata == $past(channel_range_scale))
    else $error("range read back wrong");

  chk_uv_code_write: assert property (
    (reg_wr && reg_addr == SVCR_OFS_CH1_UV) |=> fast_undervolt_threshold == $past(reg_wdata))
    else $error("undervoltage code write not stored");
  chk_read_uv_code: assert property (
    (reg_rd && reg_addr == SVCR_OFS_CH1_UV) |=> reg_rdata == $past(fast_undervolt_threshold))
    else $error("undervoltage code read back wrong");

  chk_ov_code_write: assert property (
    (reg_wr && reg_addr == SVCR_OFS_CH1_OV) |=> fast_overvolt_threshold == $past(reg_wdata))
    else $error("overvoltage code write not stored");
  chk_read_ov_code: assert property (
    (reg_rd && reg_addr == SVCR_OFS_CH1_OV) |=> reg_rdata == $past(fast_overvolt_threshold))
    else $error("overvoltage code read back wrong");

  chk_deb_write: assert property (
    (reg_wr && reg_addr == SVCR_OFS_CH1_DEB)
    |=> {overvolt_settle_code, undervolt_settle_code} == $past(reg_wdata))
    else $error("debounce write not stored");
  chk_read_deb: assert property (
    (reg_rd && reg_addr == SVCR_OFS_CH1_DEB)
    |=> reg_rdata == $past({overvolt_settle_code, undervolt_settle_code}))
    else $error("debounce read back wrong");

  chk_read_unmapped: assert property (
    (reg_rd && reg_addr == 8'h22) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_unmapped_write: assert property (
    (reg_wr && reg_addr == 8'h22) |=> $stable({s_q.test_irq, s_q.vendor_irq, s_q.ch_en})
      && $stable({s_q.range, s_q.uv_code, s_q.ov_code, s_q.deb}))
    else $error("unmapped write changed a register");
  chk_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");

  chk_low_scale_mv: assert property (
    !s_q.range[0] |=> ch1_undervolt_mv
      == 13'(SVCR_LOW_BASE_MV + int'($past(s_q.uv_code)) * SVCR_LOW_STEP_MV))
    else $error("1x undervoltage millivolts wrong");
  chk_low_scale_ov: assert property (
    !s_q.range[0] |=> ch1_overvolt_mv
      == 13'(SVCR_LOW_BASE_MV + int'($past(s_q.ov_code)) * SVCR_LOW_STEP_MV))
    else $error("1x overvoltage millivolts wrong");

  chk_high_scale_uv: assert property (
    s_q.range[0] |=> ch1_undervolt_mv
      == 13'(SVCR_HIGH_BASE_MV + int'($past(s_q.uv_code)) * SVCR_HIGH_STEP_MV))
    else $error("4x undervoltage millivolts wrong");
  chk_high_scale_ov: assert property (
    s_q.range[0] |=> ch1_overvolt_mv
      == 13'(SVCR_HIGH_BASE_MV + int'($past(s_q.ov_code)) * SVCR_HIGH_STEP_MV))
    else $error("4x overvoltage millivolts wrong");

  chk_ov_fast_code: assert property (
    (s_q.deb[7:4] == 4'h0 && s_q.ch_en[0] && ch1_ov_cmp) |=> ch1_ov_fault)
    else $error("overvoltage fault late for shortest debounce");
  chk_ov_fault_wait: assert property (
    $rose(ch1_ov_fault) |-> $past(s_q.ov_cnt) + 11'h001 >= $past(ov_limit))
    else $error("overvoltage fault before debounce time");

  chk_ov_release: assert property (
    !ch1_ov_cmp |=> !ch1_ov_fault)
    else $error("overvoltage fault held after comparator low");

  chk_uv_fast_code: assert property (
    (s_q.deb[3:0] == 4'h0 && s_q.ch_en[0] && ch1_uv_cmp) |=> ch1_uv_fault)
    else $error("undervoltage fault late for shortest debounce");
  chk_uv_fault_wait: assert property (
    $rose(ch1_uv_fault) |-> $past(s_q.uv_cnt) + 11'h001 >= $past(uv_limit))
    else $error("undervoltage fault before debounce time");

  chk_uv_release: assert property (
    !ch1_uv_cmp |=> !ch1_uv_fault)
    else $error("undervoltage fault held after comparator low");
  chk_uv_not_early: assert property (
    ($rose(ch1_uv_cmp) && s_q.ch_en[0] && s_q.deb[3:0] != 4'h0) |=> !ch1_uv_fault)
    else $error("undervoltage fault after one sample");

  chk_deb_double: assert property (
    (s_q.deb[3:0] < SVCR_DEB_MAX_CODE) |-> uv_limit == (11'h001 << s_q.deb[3:0]))
    else $error("debounce length not doubling");
  chk_deb_cap: assert property (
    (s_q.deb[3:0] >= SVCR_DEB_MAX_CODE) |-> uv_limit == 11'h400)
    else $error("debounce length not capped");

  chk_disabled_quiet: assert property (
    !s_q.ch_en[0] |=> !ch1_uv_fault && !ch1_ov_fault)
    else $error("fault on disabled channel");

  cov_ov_fault: cover property ($rose(ch1_ov_fault));
  cov_uv_fault: cover property ($rose(ch1_uv_fault));
  cov_sec_irq: cover property (irq_req.sec);
  cov_long_deb: cover property (s_q.deb[3:0] >= 4'ha && $rose(ch1_uv_fault));
  cov_disabled_cmp: cover property (!s_q.ch_en[0] && ch1_uv_cmp && ch1_ov_cmp);

endmodule

`default_nettype wire

// File: verification/svcr_host_model.sv
// Register host model driving the strobe port
`timescale 1ns/1ps
`default_nettype none
module svcr_host_model (
  // Clock
  input wire logic clock,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the channel configuration registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import svcr_pkg::*;
  logic clock, rst_b, reg_wr, reg_rd, uv, ov, uvf, ovf;
  logic [7:0] addr, wdata, rdata, en, rng, uvt, ovt, d;
  logic [12:0] uvmv, ovmv;
  logic [3:0] ovc, uvc;
  logic [4:0] ev;
  svcr_irq_t irq;
  int n_errors, checks_done, i, n;
  // Offset, write data, read back
  logic [23:0] rows [8] = '{24'h1c_ff_0b, 24'h1d_ff_a0, 24'h1e_a5_a5, 24'h1f_3c_3c,
    24'h20_7e_7e, 24'h21_81_81, 24'h24_5a_5a, 24'h22_ff_00};
  svcr_host_model host (.clock(clock), .reg_addr(addr), .reg_wr(reg_wr),
    .reg_wdata(wdata), .reg_rd(reg_rd), .reg_rdata(rdata));
  svcr_channel_regs uut (.clock(clock), .rst_b(rst_b), .reg_addr(addr), .reg_wr(reg_wr),
    .reg_wdata(wdata), .reg_rd(reg_rd), .reg_rdata(rdata), .sec_event(ev[4]),
    .selftest_done(ev[3]), .selftest_fail(ev[2]), .startup_crc_fail(ev[1]),
    .reset_output_disagree(ev[0]), .irq_req(irq), .channel_monitor_enable(en),
    .channel_range_scale(rng), .fast_undervolt_threshold(uvt),
    .fast_overvolt_threshold(ovt), .ch1_undervolt_mv(uvmv), .ch1_overvolt_mv(ovmv),
    .overvolt_settle_code(ovc), .undervolt_settle_code(uvc), .ch1_uv_cmp(uv),
    .ch1_ov_cmp(ov), .ch1_uv_fault(uvf), .ch1_ov_fault(ovf));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic evt(input logic [4:0] exp);
    @(posedge clock);
    #1;
    ev = 5'h1f;
    @(posedge clock);
    #1;
    ev = 5'h00;
    chk(irq, exp);
    @(posedge clock);
    #1;
    chk(irq, 5'h00);
  endtask
  task automatic deb(input logic [3:0] c, input int exp);
    host.wr(8'h24, {c, c});
    chk(uvc, c);
    chk(ovc, c);
    @(posedge clock);
    #1;
    uv = 1'b1;
    ov = 1'b1;
    n = 0;
    while (uvf !== 1'b1 && n < 1100) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 1100) begin
      n_errors++;
      give_verdict();
    end
    chk(n, exp);
    chk(ovf, 1'b1);
    uv = 1'b0;
    ov = 1'b0;
    @(posedge clock);
    #1;
    chk(uvf, 1'b0);
    chk(ovf, 1'b0);
  endtask
  initial begin
    n_errors = 0;
    checks_done = 0;
    rst_b = 1'b0;
    ev = 5'h00;
    uv = 1'b0;
    ov = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    rst_b = 1'b1;
    for (i = 0; i < 8; i++) begin
      host.rd(rows[i][23:16], d);
      chk(d, 8'h00);
    end
    $display("reset values done");
    for (i = 0; i < 8; i++) begin
      host.wr(rows[i][23:16], rows[i][15:8]);
      host.rd(rows[i][23:16], d);
      chk(d, rows[i][7:0]);
    end
    chk({en, rng}, 16'ha53c);
    chk({uvt, ovt}, 16'h7e81);
    chk(uvmv, 13'd830);
    chk(ovmv, 13'd845);
    host.wr(8'h1f, 8'h01);
    @(posedge clock);
    #1;
    chk(uvmv, 13'd3320);
    chk(ovmv, 13'd3380);
    $display("register rows done");
    evt(5'h1f);
    host.wr(8'h1c, 8'h08);
    host.wr(8'h1d, 8'h20);
    evt(5'h11);
    host.wr(8'h1c, 8'h00);
    host.wr(8'h1d, 8'h00);
    evt(5'h00);
    $display("interrupt gating done");
    deb(4'h0, 1);
    deb(4'h1, 2);
    deb(4'h9, 512);
    deb(4'ha, 1024);
    deb(4'hf, 1024);
    $display("debounce done");
    host.wr(8'h24, 8'h10);
    uv = 1'b1;
    ov = 1'b1;
    @(posedge clock);
    #1;
    chk({uvf, ovf}, 2'b10);
    @(posedge clock);
    #1;
    chk({uvf, ovf}, 2'b11);
    uv = 1'b0;
    ov = 1'b0;
    $display("split debounce codes done");
    host.wr(8'h24, 8'h00);
    host.wr(8'h1e, 8'h00);
    uv = 1'b1;
    ov = 1'b1;
    repeat (10) @(posedge clock);
    #1;
    chk({uvf, ovf}, 2'b00);
    $display("disabled channel done");
    rst_b = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    rst_b = 1'b1;
    chk({uvf, ovf, irq}, 7'h00);
    host.rd(8'h1e, d);
    chk(d, 8'h00);
    host.rd(8'h24, d);
    chk(d, 8'h00);
    $display("mid-run reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
